/* inc/pd_pkg.sv */
// Constants for the power-down and wake-up controller
// Behaviour
// - Arm then first sleep enters clock-run sleep; arm then second enters RAM-hold sleep
// - A sleep instruction without a prior arm does nothing
// - Enabled external wake, or timer 5 underflow in clock-run sleep, wakes; execution restarts at address 0
// - Wake sets the warm-start marker; a cold start clears it
// - Reset pin, watchdog or brownout reset give a cold start at address 0
// - Software reads the warm-start marker and the slow timer flag
// - Wake masks, pull-ups, irq control 1-3 and clock control survive sleep
// - Sleep entry initialises PC, A, B, carry, irq enables and completion flags
// - Sleep entry sets the stack level pointer to 7
// - Sleep entry clears timer run and timer four control; stops serial and converter
// - Timers 1-4 are undefined after sleep; slow timer flag is kept
// - Watchdog and its flags are initialised in sleep; software kicks it first
// - Brownout stays active in sleep only with keep instruction and enable pin high
// - Counter pin drives low in sleep unless select is 11; other ports hold
// - Unlisted state is undefined in sleep and initialised on return
// - Clock-run accepts external wake or slow timer flag; RAM-hold only external wake
// - Port 0 and 1 pins wake on low when their mask bit is set
// - Interrupt pins wake by chosen level or by edge, per control registers
// - Slow timer flag at 1 wakes clock-run sleep, even at entry
// - Wake mask registers are written and read back through the register port
// - Pull-up control registers are written and read back
// - Interrupt control registers select waveform, input enable and wake level
package pd_pkg;
	localparam int DATA_W = 4;
	localparam int ADDR_W = 4;
	localparam logic [3:0] A_P0_MASK = 4'h0;
	localparam logic [3:0] A_P1_MASK = 4'h1;
	localparam logic [3:0] A_IRQ_WAKE = 4'h2;
	localparam logic [3:0] A_P0_PULLUP = 4'h3;
	localparam logic [3:0] A_P1_PULLUP = 4'h4;
	localparam logic [3:0] A_IRQ_A_CTRL = 4'h5;
	localparam logic [3:0] A_IRQ_B_CTRL = 4'h6;
	localparam logic [3:0] A_IRQ_THIRD = 4'h7;
	localparam logic [3:0] A_CLOCK_CTRL = 4'h8;
	localparam logic [3:0] A_TIMER_RUN = 4'h9;
	localparam logic [3:0] A_TIMER_FOUR = 4'ha;
	localparam logic [3:0] A_IRQ_EN_A = 4'hb;
	localparam logic [3:0] A_IRQ_EN_B = 4'hc;
	localparam logic [3:0] A_STATUS = 4'hd;
	localparam logic [3:0] A_COMMAND = 4'he;
	// Command bits, one instruction each
	localparam int C_ARM = 0;
	localparam int C_CLK_SLEEP = 1;
	localparam int C_RAM_SLEEP = 2;
	localparam int C_MISC = 3;
	// With C_MISC set, bits 2:0 select a miscellaneous instruction
	localparam logic [2:0] M_KICK = 3'h1;
	localparam logic [2:0] M_KEEP_BO = 3'h2;
	localparam logic [2:0] M_TEST_CLR = 3'h3;
	// Status bits
	localparam int S_WARM = 0;
	localparam int S_SLOW = 1;
	localparam int S_ARMED = 2;
	localparam int S_KEEP_BO = 3;
	// External interrupt control fields
	localparam int I_WAVE = 0;
	localparam int I_INEN = 1;
	localparam int I_LEVEL = 2;
	// Wake control fields for the two interrupt pins
	localparam int K_A_EN = 0;
	localparam int K_A_EDGE = 1;
	localparam int K_B_EN = 2;
	localparam int K_B_EDGE = 3;
	localparam logic [3:0] REG_RESET = 4'h0;
	localparam logic [2:0] STACK_INIT = 3'h7;
	localparam logic [1:0] CNT_INPUT_SEL = 2'h3;
	localparam int CLOCK_MHZ = 200;
	localparam int OSC_SETTLE_NS = 100;
	localparam int SETTLE_CYCLES = (OSC_SETTLE_NS * CLOCK_MHZ + 999) / 1000;
	typedef enum logic [1:0] {
		ST_RUN = 2'b00,
		ST_CLK_SLEEP = 2'b01,
		ST_RAM_SLEEP = 2'b10,
		ST_SETTLE = 2'b11
	} mode_type;
endpackage

/* rtl/power_down_wakeup_control.sv */
// Power-down sequencing, wake detection and warm/cold start marking
`timescale 1ns/1ps
module power_down_wakeup_control #(
	parameter int SETTLE = pd_pkg::SETTLE_CYCLES
) (
	input wire logic CLOCK,
	input wire logic RST_N,
	input wire logic [pd_pkg::ADDR_W-1:0] ADDR,
	input wire logic [pd_pkg::DATA_W-1:0] WDATA,
	input wire logic WR,
	input wire logic RD,
	output logic [pd_pkg::DATA_W-1:0] RDATA,
	input wire logic [3:0] PORT0_IN,
	input wire logic [3:0] PORT1_IN,
	input wire logic EXT_IRQ_A_PIN,
	input wire logic EXT_IRQ_B_PIN,
	input wire logic RESET_PIN_N,
	input wire logic BROWNOUT_ENABLE_PIN,
	input wire logic BROWNOUT_TRIP,
	input wire logic WATCHDOG_RESET,
	input wire logic TIMER5_UNDERFLOW,
	input wire logic [1:0] COUNTER_PIN_SELECT_BITS,
	input wire logic COUNTER_DRIVE,
	input wire logic COUNTER_DRIVE_EN,
	output logic CPU_RESTART,
	output logic COLD_START,
	output logic SLEEP_INIT,
	output logic [2:0] STACK_LEVEL_POINTER,
	output logic CPU_HALT,
	output logic MAIN_OSC_EN,
	output logic SUB_OSC_EN,
	output logic TIMER5_RUN,
	output logic LCD_ON,
	output logic TIMERS_UNDEFINED,
	output logic WATCHDOG_INIT,
	output logic WATCHDOG_KICK,
	output logic SERIAL_CONVERTER_STOP,
	output logic BROWNOUT_ACTIVE,
	output logic PORT_HOLD,
	output logic COUNTER_IO_PIN_OUT,
	output logic COUNTER_IO_PIN_OE,
	output logic [3:0] PORT0_PULLUP,
	output logic [3:0] PORT1_PULLUP
);
	import pd_pkg::*;

	// The settle counter is 16 bits wide and must count at least one cycle
	if (SETTLE < 1 || SETTLE > 65535) begin
		$error("SETTLE out of range");
	end

	localparam int SYNC_W = 13;
	localparam logic [SYNC_W-1:0] SYNC_IDLE = 13'h0fff;

	// Two-flop synchronisers for everything that arrives from pins
	logic [SYNC_W-1:0] sync1;
	logic [SYNC_W-1:0] sync2;
	wire [SYNC_W-1:0] pins_raw = {BROWNOUT_TRIP, BROWNOUT_ENABLE_PIN, RESET_PIN_N,
		EXT_IRQ_B_PIN, EXT_IRQ_A_PIN, PORT1_IN, PORT0_IN};

	always_ff @(posedge CLOCK) begin
		if (!RST_N) begin
			sync1 <= SYNC_IDLE;
			sync2 <= SYNC_IDLE;
		end else begin
			sync1 <= pins_raw;
			sync2 <= sync1;
		end
	end

	wire [3:0] port0_s = sync2[3:0];
	wire [3:0] port1_s = sync2[7:4];
	wire irq_a_s = sync2[8];
	wire irq_b_s = sync2[9];
	wire reset_pin_s_n = sync2[10];
	wire bo_enable_s = sync2[11];
	wire bo_trip_s = sync2[12];

	// Registers
	mode_type mode;
	mode_type next_mode;
	logic [3:0] port0_wake_mask;
	logic [3:0] port1_wake_mask;
	logic [3:0] ext_irq_wake_ctrl;
	logic [3:0] port0_pullup_ctrl;
	logic [3:0] port1_pullup_ctrl;
	logic [3:0] ext_irq_a_ctrl;
	logic [3:0] ext_irq_b_ctrl;
	logic [3:0] interrupt_ctrl_third;
	logic [3:0] clock_control_reg;
	logic [3:0] timer_run_ctrl;
	logic [3:0] timer_four_ctrl;
	logic [3:0] irq_enable_reg_a;
	logic [3:0] irq_enable_reg_b;
	logic warm_start;
	logic slow_timer_flag;
	logic armed;
	logic keep_brownout;
	logic [15:0] settle_count;
	logic irq_a_prev;
	logic irq_b_prev;

	// Decode of the register port
	wire wr_cmd = WR && ADDR == A_COMMAND;
	wire is_misc = WDATA[C_MISC];
	wire do_arm = wr_cmd && !is_misc && WDATA[C_ARM];
	wire do_clk_sleep = wr_cmd && !is_misc && WDATA[C_CLK_SLEEP];
	wire do_ram_sleep = wr_cmd && !is_misc && WDATA[C_RAM_SLEEP];
	wire do_kick = wr_cmd && is_misc && WDATA[2:0] == M_KICK;
	wire do_keep_bo = wr_cmd && is_misc && WDATA[2:0] == M_KEEP_BO;
	wire do_test_clr = wr_cmd && is_misc && WDATA[2:0] == M_TEST_CLR;

	wire awake = mode == ST_RUN;
	wire asleep = mode == ST_CLK_SLEEP || mode == ST_RAM_SLEEP;
	// Sleep without arm is ignored entirely
	wire enter_clk = awake && armed && do_clk_sleep;
	wire enter_ram = awake && armed && do_ram_sleep && !do_clk_sleep;
	wire enter_sleep = enter_clk || enter_ram;

	// Brownout only counts outside sleep (run or settle), or in sleep after the keep instruction
	wire bo_active = bo_enable_s && (!asleep || keep_brownout);
	wire cold_event = !reset_pin_s_n || WATCHDOG_RESET || (bo_active && bo_trip_s);
	wire clear_all = !RST_N || cold_event;

	// Wake sources
	wire key_wake = |(port0_wake_mask & ~port0_s) || |(port1_wake_mask & ~port1_s);
	wire level_a = ext_irq_a_ctrl[I_LEVEL];
	wire level_b = ext_irq_b_ctrl[I_LEVEL];
	// Edge mode wakes on the transition toward the chosen level
	wire edge_a = irq_a_s == level_a && irq_a_prev != level_a;
	wire edge_b = irq_b_s == level_b && irq_b_prev != level_b;
	wire hit_a = ext_irq_wake_ctrl[K_A_EDGE] ? edge_a : irq_a_s == level_a;
	wire hit_b = ext_irq_wake_ctrl[K_B_EDGE] ? edge_b : irq_b_s == level_b;
	wire irq_wake = (ext_irq_wake_ctrl[K_A_EN] && hit_a) || (ext_irq_wake_ctrl[K_B_EN] && hit_b);
	wire ext_wake = key_wake || irq_wake;
	// Timer wake only exists in clock-run sleep; RAM-hold has no running oscillator
	wire timer_wake = slow_timer_flag || TIMER5_UNDERFLOW;
	wire wake = (mode == ST_CLK_SLEEP && (ext_wake || timer_wake))
		|| (mode == ST_RAM_SLEEP && ext_wake);
	wire settled = settle_count == 16'(SETTLE - 1);

	always_comb begin
		next_mode = mode;
		case (mode)
			ST_RUN: begin
				if (enter_clk) begin
					next_mode = ST_CLK_SLEEP;
				end else if (enter_ram) begin
					next_mode = ST_RAM_SLEEP;
				end
			end
			ST_CLK_SLEEP, ST_RAM_SLEEP: begin
				if (wake) begin
					next_mode = ST_SETTLE;
				end
			end
			ST_SETTLE: begin
				if (settled) begin
					next_mode = ST_RUN;
				end
			end
			default: next_mode = ST_RUN;
		endcase
	end

	wire restart_now = mode == ST_SETTLE && settled;

	always_ff @(posedge CLOCK) begin
		if (clear_all) begin
			mode <= ST_RUN;
			settle_count <= 16'h0000;
		end else begin
			mode <= next_mode;
			if (mode == ST_SETTLE) begin
				settle_count <= settle_count + 16'h0001;
			end else begin
				settle_count <= 16'h0000;
			end
		end
	end

	always_ff @(posedge CLOCK) begin
		if (clear_all) begin
			irq_a_prev <= 1'b1;
			irq_b_prev <= 1'b1;
		end else begin
			irq_a_prev <= irq_a_s;
			irq_b_prev <= irq_b_s;
		end
	end

	// Software-written configuration; none of it is touched by sleep
	wire wr_p0 = WR && ADDR == A_P0_MASK;
	wire wr_p1 = WR && ADDR == A_P1_MASK;
	wire wr_kw = WR && ADDR == A_IRQ_WAKE;
	wire wr_u0 = WR && ADDR == A_P0_PULLUP;
	wire wr_u1 = WR && ADDR == A_P1_PULLUP;
	wire wr_ia = WR && ADDR == A_IRQ_A_CTRL;
	wire wr_ib = WR && ADDR == A_IRQ_B_CTRL;
	wire wr_i3 = WR && ADDR == A_IRQ_THIRD;
	wire wr_mr = WR && ADDR == A_CLOCK_CTRL;

	always_ff @(posedge CLOCK) begin
		if (clear_all) begin
			port0_wake_mask <= REG_RESET;
			port1_wake_mask <= REG_RESET;
			ext_irq_wake_ctrl <= REG_RESET;
			port0_pullup_ctrl <= REG_RESET;
			port1_pullup_ctrl <= REG_RESET;
			ext_irq_a_ctrl <= REG_RESET;
			ext_irq_b_ctrl <= REG_RESET;
			interrupt_ctrl_third <= REG_RESET;
			clock_control_reg <= REG_RESET;
		end else begin
			if (wr_p0) begin
				port0_wake_mask <= WDATA;
			end
			if (wr_p1) begin
				port1_wake_mask <= WDATA;
			end
			if (wr_kw) begin
				ext_irq_wake_ctrl <= WDATA;
			end
			if (wr_u0) begin
				port0_pullup_ctrl <= WDATA;
			end
			if (wr_u1) begin
				port1_pullup_ctrl <= WDATA;
			end
			if (wr_ia) begin
				ext_irq_a_ctrl <= WDATA;
			end
			if (wr_ib) begin
				ext_irq_b_ctrl <= WDATA;
			end
			if (wr_i3) begin
				interrupt_ctrl_third <= WDATA;
			end
			if (wr_mr) begin
				clock_control_reg <= WDATA;
			end
		end
	end

	// Registers that sleep entry initialises
	always_ff @(posedge CLOCK) begin
		if (clear_all || enter_sleep) begin
			timer_run_ctrl <= REG_RESET;
			timer_four_ctrl <= REG_RESET;
			irq_enable_reg_a <= REG_RESET;
			irq_enable_reg_b <= REG_RESET;
		end else begin
			if (WR && ADDR == A_TIMER_RUN) begin
				timer_run_ctrl <= WDATA;
			end
			if (WR && ADDR == A_TIMER_FOUR) begin
				timer_four_ctrl <= WDATA;
			end
			if (WR && ADDR == A_IRQ_EN_A) begin
				irq_enable_reg_a <= WDATA;
			end
			if (WR && ADDR == A_IRQ_EN_B) begin
				irq_enable_reg_b <= WDATA;
			end
		end
	end

	// Flags
	always_ff @(posedge CLOCK) begin
		if (clear_all) begin
			warm_start <= 1'b0;
			slow_timer_flag <= 1'b0;
			armed <= 1'b0;
			keep_brownout <= 1'b0;
		end else begin
			if (restart_now) begin
				warm_start <= 1'b1;
			end
			// Underflow beats a same-cycle test-and-clear; the flag survives sleep
			if (TIMER5_UNDERFLOW) begin
				slow_timer_flag <= 1'b1;
			end else if (do_test_clr) begin
				slow_timer_flag <= 1'b0;
			end
			// Any sleep instruction uses up the arm, valid or not
			if (do_clk_sleep || do_ram_sleep) begin
				armed <= 1'b0;
			end else if (do_arm) begin
				armed <= 1'b1;
			end
			if (do_keep_bo) begin
				keep_brownout <= 1'b1;
			end
		end
	end

	// Read path, data one cycle after the strobe
	wire [3:0] status = {keep_brownout, armed, slow_timer_flag, warm_start};
	logic [3:0] read_mux;
	always_comb begin
		case (ADDR)
			A_P0_MASK: read_mux = port0_wake_mask;
			A_P1_MASK: read_mux = port1_wake_mask;
			A_IRQ_WAKE: read_mux = ext_irq_wake_ctrl;
			A_P0_PULLUP: read_mux = port0_pullup_ctrl;
			A_P1_PULLUP: read_mux = port1_pullup_ctrl;
			A_IRQ_A_CTRL: read_mux = ext_irq_a_ctrl;
			A_IRQ_B_CTRL: read_mux = ext_irq_b_ctrl;
			A_IRQ_THIRD: read_mux = interrupt_ctrl_third;
			A_CLOCK_CTRL: read_mux = clock_control_reg;
			A_TIMER_RUN: read_mux = timer_run_ctrl;
			A_TIMER_FOUR: read_mux = timer_four_ctrl;
			A_IRQ_EN_A: read_mux = irq_enable_reg_a;
			A_IRQ_EN_B: read_mux = irq_enable_reg_b;
			A_STATUS: read_mux = status;
			default: read_mux = REG_RESET;
		endcase
	end

	always_ff @(posedge CLOCK) begin
		if (!RST_N) begin
			RDATA <= REG_RESET;
		end else begin
			RDATA <= RD ? read_mux : REG_RESET;
		end
	end

	// Power and pin outputs, all registered
	wire next_counter_oe = asleep ? COUNTER_PIN_SELECT_BITS != CNT_INPUT_SEL
		: COUNTER_DRIVE_EN;
	wire next_counter_out = asleep ? 1'b0 : COUNTER_DRIVE;
	wire next_clk_sleep = next_mode == ST_CLK_SLEEP;
	wire next_ram_sleep = next_mode == ST_RAM_SLEEP;

	always_ff @(posedge CLOCK) begin
		if (clear_all) begin
			CPU_RESTART <= 1'b1;
			COLD_START <= 1'b1;
			SLEEP_INIT <= 1'b0;
			STACK_LEVEL_POINTER <= STACK_INIT;
			CPU_HALT <= 1'b0;
			MAIN_OSC_EN <= 1'b1;
			SUB_OSC_EN <= 1'b1;
			TIMER5_RUN <= 1'b1;
			LCD_ON <= 1'b1;
			TIMERS_UNDEFINED <= 1'b0;
			WATCHDOG_INIT <= 1'b0;
			WATCHDOG_KICK <= 1'b0;
			SERIAL_CONVERTER_STOP <= 1'b0;
			BROWNOUT_ACTIVE <= 1'b0;
			PORT_HOLD <= 1'b0;
			COUNTER_IO_PIN_OUT <= 1'b0;
			COUNTER_IO_PIN_OE <= 1'b0;
		end else begin
			CPU_RESTART <= restart_now;
			COLD_START <= 1'b0;
			SLEEP_INIT <= enter_sleep;
			STACK_LEVEL_POINTER <= STACK_INIT;
			CPU_HALT <= next_mode != ST_RUN;
			// RAM-hold stops the main oscillator; a wake restarts it before execution
			MAIN_OSC_EN <= !next_ram_sleep;
			SUB_OSC_EN <= !next_ram_sleep;
			TIMER5_RUN <= !next_ram_sleep;
			LCD_ON <= !next_ram_sleep;
			// Timers 1-4 are stale once a sleep has happened, until software reloads
			if (enter_sleep) begin
				TIMERS_UNDEFINED <= 1'b1;
			end else if (WR && ADDR == A_TIMER_RUN) begin
				TIMERS_UNDEFINED <= 1'b0;
			end
			WATCHDOG_INIT <= next_clk_sleep || next_ram_sleep;
			WATCHDOG_KICK <= do_kick;
			SERIAL_CONVERTER_STOP <= next_mode != ST_RUN;
			BROWNOUT_ACTIVE <= bo_active;
			PORT_HOLD <= next_clk_sleep || next_ram_sleep;
			COUNTER_IO_PIN_OUT <= next_counter_out;
			COUNTER_IO_PIN_OE <= next_counter_oe;
		end
	end

	assign PORT0_PULLUP = port0_pullup_ctrl;
	assign PORT1_PULLUP = port1_pullup_ctrl;
endmodule

/* tb/pd_checker.sv */
// Port-level assertions for the power-down controller
`timescale 1ns/1ps
module pd_checker #(
	parameter int SETTLE = pd_pkg::SETTLE_CYCLES
) (
	input wire logic CLOCK,
	input wire logic RST_N,
	input wire logic [pd_pkg::ADDR_W-1:0] ADDR,
	input wire logic [pd_pkg::DATA_W-1:0] WDATA,
	input wire logic WR,
	input wire logic WATCHDOG_RESET,
	input wire logic [1:0] COUNTER_PIN_SELECT_BITS,
	input wire logic CPU_RESTART,
	input wire logic COLD_START,
	input wire logic SLEEP_INIT,
	input wire logic [2:0] STACK_LEVEL_POINTER,
	input wire logic CPU_HALT,
	input wire logic MAIN_OSC_EN,
	input wire logic SUB_OSC_EN,
	input wire logic TIMER5_RUN,
	input wire logic LCD_ON,
	input wire logic WATCHDOG_INIT,
	input wire logic SERIAL_CONVERTER_STOP,
	input wire logic PORT_HOLD,
	input wire logic COUNTER_IO_PIN_OUT,
	input wire logic COUNTER_IO_PIN_OE,
	input wire logic [3:0] PORT0_PULLUP
);
	import pd_pkg::*;
	logic armed;
	wire cmd = WR && ADDR == A_COMMAND && !WDATA[C_MISC];
	wire go_sleep = cmd && (WDATA[C_CLK_SLEEP] || WDATA[C_RAM_SLEEP]);
	// Shadow of the arm state, cleared by any cold start like the device
	always_ff @(posedge CLOCK) begin
		if (!RST_N || COLD_START)
			armed <= 1'h0;
		else if (cmd)
			armed <= go_sleep ? 1'h0 : (armed | WDATA[C_ARM]);
	end
	default clocking @(posedge CLOCK); endclocking
	default disable iff (!RST_N);
	AST_ENTER: assert property (
		go_sleep && armed && !CPU_HALT |-> ##[1:2] (CPU_HALT && SLEEP_INIT))
		else $error("armed sleep not entered");
	AST_NOARM: assert property (
		go_sleep && !armed && !CPU_HALT |=> !CPU_HALT [*2])
		else $error("unarmed sleep halted");
	AST_OSC: assert property (
		{SUB_OSC_EN, TIMER5_RUN, LCD_ON} == {3{MAIN_OSC_EN}} && (MAIN_OSC_EN || CPU_HALT))
		else $error("clock enables wrong for mode");
	AST_STACK: assert property (STACK_LEVEL_POINTER == STACK_INIT)
		else $error("stack pointer not 7");
	AST_ASLEEP: assert property (
		$rose(CPU_HALT) |-> WATCHDOG_INIT && SERIAL_CONVERTER_STOP && PORT_HOLD)
		else $error("sleep side effects missing");
	AST_CNTPIN: assert property (
		PORT_HOLD && $past(PORT_HOLD) |-> !COUNTER_IO_PIN_OUT &&
		COUNTER_IO_PIN_OE == ($past(COUNTER_PIN_SELECT_BITS) != CNT_INPUT_SEL))
		else $error("counter pin wrong in sleep");
	AST_RESTART: assert property (
		$fell(CPU_HALT) && !COLD_START |-> CPU_RESTART && $past(CPU_HALT, SETTLE))
		else $error("warm restart wrong");
	AST_COLD: assert property (WATCHDOG_RESET |=> COLD_START && CPU_RESTART)
		else $error("watchdog cold start missing");
	AST_PULLUP: assert property (
		WR && ADDR == A_P0_PULLUP |=> PORT0_PULLUP == $past(WDATA))
		else $error("pull-up output not updated");
	cover property (go_sleep && armed && WDATA[C_RAM_SLEEP]);
	cover property ($fell(CPU_HALT) && !COLD_START);
	cover property (!MAIN_OSC_EN);
endmodule
bind power_down_wakeup_control pd_checker #(.SETTLE(SETTLE)) u_chk (.*);

/* tb/power_down_wakeup_control_tb.sv */
// Self-checking bench for the power-down controller
`timescale 1ns/1ps
module power_down_wakeup_control_tb;
	import pd_pkg::*;
	localparam int SET = 4;
	logic CLOCK, RST_N, WR, RD, WATCHDOG_RESET, TIMER5_UNDERFLOW, COUNTER_DRIVE, COUNTER_DRIVE_EN;
	logic [3:0] ADDR, WDATA, RDATA, PORT0_IN, PORT1_IN, PORT0_PULLUP, PORT1_PULLUP;
	logic [1:0] COUNTER_PIN_SELECT_BITS, irq_lvl;
	logic [7:0] key_low;
	logic rst_req, bo_en, bo_trip, EXT_IRQ_A_PIN, EXT_IRQ_B_PIN, RESET_PIN_N;
	logic BROWNOUT_ENABLE_PIN, BROWNOUT_TRIP, CPU_RESTART, COLD_START, SLEEP_INIT, CPU_HALT;
	logic MAIN_OSC_EN, SUB_OSC_EN, TIMER5_RUN, LCD_ON, TIMERS_UNDEFINED, WATCHDOG_INIT;
	logic WATCHDOG_KICK, SERIAL_CONVERTER_STOP, BROWNOUT_ACTIVE, PORT_HOLD;
	logic COUNTER_IO_PIN_OUT, COUNTER_IO_PIN_OE;
	logic [2:0] STACK_LEVEL_POINTER;
	int m[16];
	bit warm, slow, keep, armed;
	int failures, num_checks;
	power_down_wakeup_control #(.SETTLE(SET)) DUT (.*);
	wake_partner u_far (.key_low(key_low), .irq_lvl(irq_lvl), .rst_req(rst_req),
		.bo_en(bo_en), .bo_trip(bo_trip), .port0_in(PORT0_IN), .port1_in(PORT1_IN),
		.irq_a(EXT_IRQ_A_PIN), .irq_b(EXT_IRQ_B_PIN), .reset_n(RESET_PIN_N),
		.bo_enable(BROWNOUT_ENABLE_PIN), .bo_low(BROWNOUT_TRIP));
	initial begin
		CLOCK = 1'h0;
		forever #2.5 CLOCK = ~CLOCK;
	end
	task automatic complete_run();
		$display("checks %0d failures %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task automatic check(string name, logic [3:0] seen, logic [3:0] exp);
		num_checks++;
		if (seen !== exp) begin
			failures++;
			$display("[ERR] %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic wait_for(ref logic s, input logic v);
		int n = 0;
		#1;
		while (s !== v) begin
			@(posedge CLOCK);
			#1 n++;
			if (n > 300) begin
				failures++;
				complete_run();
			end
		end
	endtask
	task automatic cycles(int n);
		repeat (n) @(posedge CLOCK);
		#1;
	endtask
	task automatic wr(logic [3:0] a, logic [3:0] d);
		@(posedge CLOCK);
		{ADDR, WDATA, WR} <= {a, d, 1'h1};
		@(posedge CLOCK);
		WR <= 1'h0;
		if (a < A_STATUS) m[a] = d;
	endtask
	task automatic rd(logic [3:0] a);
		@(posedge CLOCK);
		{ADDR, RD} <= {a, 1'h1};
		@(posedge CLOCK);
		RD <= 1'h0;
		#1 check("rdata", RDATA, a == A_STATUS ? {keep, armed, slow, warm} : m[a]);
	endtask
	task automatic cmd(logic [3:0] d);
		wr(A_COMMAND, d);
		// Miscellaneous instructions leave the arm alone; any sleep uses it up
		if (!d[C_MISC]) armed = (d[2:1] == 2'h0) && (armed || d[C_ARM]);
		if (d == 4'ha) keep = 1;
		if (d == 4'hb) slow = 0;
	endtask
	task automatic sleep(logic [3:0] d);
		cmd(4'h1);
		COUNTER_PIN_SELECT_BITS <= $urandom;
		cmd(d);
		for (int a = 9; a < 13; a++) m[a] = 0;
		cycles(1);
		check("halt", CPU_HALT, 1);
		check("timers undef", TIMERS_UNDEFINED, 1);
	endtask
	task automatic wake();
		wait_for(CPU_RESTART, 1'h1);
		warm = 1;
		check("halt", CPU_HALT, 0);
	endtask
	initial begin
		{RST_N, WR, RD, WATCHDOG_RESET, TIMER5_UNDERFLOW, rst_req, bo_trip} = '0;
		{ADDR, WDATA, key_low, irq_lvl} = '0;
		bo_en = 1'h1;
		void'($urandom(83360));
		{COUNTER_PIN_SELECT_BITS, COUNTER_DRIVE, COUNTER_DRIVE_EN} = $urandom;
		repeat (10) @(posedge CLOCK);
		RST_N <= 1'h1;
		wait_for(COLD_START, 1'h0);
		for (int a = 0; a < 16; a++) rd(a);
		for (int a = 0; a < 14; a++) wr(a, $urandom);
		for (int a = 0; a < 16; a++) rd(a);
		check("pullup1", PORT1_PULLUP, m[4]);
		check("timers undef", TIMERS_UNDEFINED, 0);
		check("cnt out awake", COUNTER_IO_PIN_OUT, COUNTER_DRIVE);
		check("cnt oe awake", COUNTER_IO_PIN_OE, COUNTER_DRIVE_EN);
		cmd(4'h2);
		cycles(2);
		check("halt", CPU_HALT, 0);
		wr(A_P0_MASK, 4'h1);
		// Port 1 mask left random would let the low port 1 pin below wake early
		wr(A_P1_MASK, 4'h0);
		wr(A_IRQ_WAKE, 4'h0);
		cmd(4'h9);
		#1 check("kick", WATCHDOG_KICK, 1);
		sleep(4'h2);
		cycles(1);
		check("main osc", MAIN_OSC_EN, 1);
		check("cnt out", COUNTER_IO_PIN_OUT, 0);
		check("cnt oe", COUNTER_IO_PIN_OE, COUNTER_PIN_SELECT_BITS != 2'h3);
		key_low <= 8'h12;
		cycles(20);
		check("halt", CPU_HALT, 1);
		key_low <= 8'h01;
		wake();
		key_low <= 8'h00;
		for (int a = 0; a < 16; a++) rd(a);
		sleep(4'h2);
		TIMER5_UNDERFLOW <= 1'h1;
		@(posedge CLOCK) TIMER5_UNDERFLOW <= 1'h0;
		wake();
		slow = 1;
		rd(A_STATUS);
		sleep(4'h2);
		wake();
		cmd(4'hb);
		rd(A_STATUS);
		wr(A_IRQ_WAKE, 4'h1);
		wr(A_IRQ_A_CTRL, 4'h6);
		sleep(4'h4);
		check("main osc", MAIN_OSC_EN, 0);
		check("brownout", BROWNOUT_ACTIVE, 0);
		TIMER5_UNDERFLOW <= 1'h1;
		@(posedge CLOCK) TIMER5_UNDERFLOW <= 1'h0;
		cycles(20);
		check("halt", CPU_HALT, 1);
		slow = 1;
		rd(A_STATUS);
		irq_lvl <= 2'h1;
		wake();
		cmd(4'hb);
		rd(A_STATUS);
		// Pin B high at entry: a level wake would fire here, an edge wake must not
		cmd(4'ha);
		wr(A_IRQ_WAKE, 4'hc);
		wr(A_IRQ_B_CTRL, 4'h6);
		irq_lvl <= 2'h2;
		sleep(4'h4);
		check("brownout", BROWNOUT_ACTIVE, 1);
		cycles(20);
		check("halt", CPU_HALT, 1);
		irq_lvl <= 2'h0;
		cycles(5);
		irq_lvl <= 2'h2;
		wake();
		for (int k = 0; k < 3; k++) begin
			{bo_trip, rst_req, WATCHDOG_RESET} <= 3'h1 << k;
			cycles(3);
			{bo_trip, rst_req, WATCHDOG_RESET} <= 3'h0;
			wait_for(COLD_START, 1'h1);
			wait_for(COLD_START, 1'h0);
			m = '{default: 0};
			{warm, slow, keep, armed} = '0;
			rd(A_STATUS);
			rd(A_P0_MASK);
			wr(A_P0_MASK, 4'h1);
		end
		complete_run();
	end
endmodule

/* tb/wake_partner.sv */
// Far-side model: key pins, interrupt pins, reset pin and brownout detector
`timescale 1ns/1ps
module wake_partner (
	input wire logic [7:0] key_low,
	input wire logic [1:0] irq_lvl,
	input wire logic rst_req,
	input wire logic bo_en,
	input wire logic bo_trip,
	output logic [3:0] port0_in,
	output logic [3:0] port1_in,
	output logic irq_a,
	output logic irq_b,
	output logic reset_n,
	output logic bo_enable,
	output logic bo_low
);
	// Released keys sit high on their pull-ups, so pins are high before sleep
	assign port0_in = ~key_low[3:0];
	assign port1_in = ~key_low[7:4];
	// Levels are set to suit the chosen wake level or edge
	assign irq_a = irq_lvl[0];
	assign irq_b = irq_lvl[1];
	assign reset_n = ~rst_req;
	assign bo_enable = bo_en;
	assign bo_low = bo_trip;
endmodule
